// [logic/asp_pkg.sv]
// Shared constants for the converter serial port and convert control.
// Assumes both ends include nothing else; all users name asp_pkg:: explicitly.
package asp_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int RESULT_BITS = 13;
  localparam int DATA_BITS = 12;
  localparam int WR_BIT = 15;
  localparam int ADDR_LO = 13;
  localparam logic [1:0] ADDR_CFG = 2'h0;
  localparam logic [1:0] ADDR_LIM_LOW = 2'h1;
  localparam logic [1:0] ADDR_LIM_HIGH = 2'h2;

  // ----------------------------------------
  // Configuration fields and reset values
  // ----------------------------------------
  localparam int CFG_BITS = 4;
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_GPO0_BIT = 2;
  localparam int CFG_GENERAL_OUTPUT_ONE_BIT = 3;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [11:0] LIM_LOW_RST = 12'h000;
  localparam logic [11:0] LIM_HIGH_RST = 12'hFFF;

  typedef enum logic [1:0] {
    ASP_MODE_ALERT,
    ASP_MODE_BUSY,
    ASP_MODE_GPO,
    ASP_MODE_SPARE
  } asp_mode_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS = 600;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONVERT_START_N_LOW_NS = 40;
  localparam int CONVERT_START_N_LOW_CYCLES = (CONVERT_START_N_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES = 4;
  localparam int CS_LEAD_CYCLES = 6;
  localparam int CS_GAP_CYCLES = 4;
  localparam int FIFO_DEPTH = 16;

endpackage

// [logic/asp_link_if.sv]
// Serial link between the converter and its host.
// Assumes the host drives clock, select, data in and convert start.
`timescale 1ns/1ps
interface asp_link_if;
  logic serial_clock;
  logic chip_select_n;
  logic serial_data_in;
  logic serial_data_out;
  logic serial_data_out_oe_n;
  logic convert_start_n;
  logic shared_status_output;
  logic general_output_one;
  logic serial_data_out_line;

  // Released line reads high, as with a pull-up
  assign serial_data_out_line = serial_data_out_oe_n ? 1'b1 : serial_data_out;

  modport dev (
    input serial_clock, chip_select_n, serial_data_in, convert_start_n,
    output serial_data_out, serial_data_out_oe_n, shared_status_output, general_output_one
  );
  modport host (
    output serial_clock, chip_select_n, serial_data_in, convert_start_n,
    input serial_data_out_line, shared_status_output, general_output_one
  );
endinterface

// [logic/asp_dev.sv]
// Converter end: serial port on the link clock, convert control on i_clk.
// Assumes the host keeps select high between frames and the link clock idle high.
//
// Function
// R01 - Port acts only while select low
// R02 - Each result frame starts after select falls
// R03 - Received bits load control registers
// R04 - Data in sampled on rising clock edge
// R05 - Host sends write data MSB first
// R06 - Result leaves as a serial stream
// R07 - Result bits change on falling edge
// R08 - Host gives thirteen clocks per result; the host gives sixteen per frame, with the result in the first thirteen
// R09 - Result sent MSB first
// R10 - Convert start falling edge starts conversion
// R11 - Config selects shared output function
// R12 - Alert mode flags out-of-limit result
// R13 - Busy mode flags conversion in progress
// R14 - GPO mode drives config level
// R15 - Data out released while select high
// R16 - Reset asynchronously restores config and port
`timescale 1ns/1ps
module asp_dev #(
  parameter int CONV_CYCLES = asp_pkg::CONV_CYCLES
) (
  asp_link_if.dev link,
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [11:0] i_sample,
  output logic o_hold_pulse
);

  generate
    if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_bad
      $error("CONV_CYCLES must be 1 to 255");
    end
  endgenerate

  // ----------------------------------------
  // Link domain, rising edge: shift in
  // ----------------------------------------
  // Select high holds the port in reset, so clock and data are ignored
  logic frame_rst;
  assign frame_rst = i_rst | link.chip_select_n; // R01 R16

  logic [4:0] in_cnt_reg, in_cnt_next;
  logic [15:0] in_shift_reg, in_shift_next;
  logic in_done;

  always_comb begin
    in_shift_next = {in_shift_reg[14:0], link.serial_data_in}; // R04 R05
    in_cnt_next = in_cnt_reg + 5'h01;
    // Count stops past the last bit, so extra rises never rewrite the word
    in_done = in_cnt_reg == 5'(asp_pkg::FRAME_BITS);
    if (in_done) begin
      in_cnt_next = in_cnt_reg;
    end
  end

  always_ff @(posedge link.serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      in_cnt_reg <= 5'h00;
      in_shift_reg <= 16'h0000;
    end else begin
      in_cnt_reg <= in_cnt_next;
      in_shift_reg <= in_shift_next;
    end
  end

  // Completed word and its toggle live across frames
  logic [15:0] word_reg, word_next;
  logic word_tgl_reg, word_tgl_next;

  always_comb begin
    word_next = word_reg;
    word_tgl_next = word_tgl_reg;
    // Last rise of the frame: shift register plus this bit is the whole word
    if (!link.chip_select_n && in_cnt_reg == 5'(asp_pkg::FRAME_BITS - 1)) begin
      word_next = in_shift_next; // R03
      word_tgl_next = ~word_tgl_reg;
    end
  end

  always_ff @(posedge link.serial_clock or posedge i_rst) begin
    if (i_rst) begin
      word_reg <= 16'h0000;
      word_tgl_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      word_tgl_reg <= word_tgl_next;
    end
  end

  // ----------------------------------------
  // Link domain, falling edge: shift out
  // ----------------------------------------
  logic [12:0] hold_reg;
  logic [12:0] out_shift_reg, out_shift_next;
  logic sdo_reg, sdo_next;
  logic oe_n_reg;

  always_comb begin
    // First falling edge of a frame loads the held result
    if (oe_n_reg) begin
      sdo_next = hold_reg[12]; // R02 R09
      out_shift_next = {hold_reg[11:0], 1'b0};
    end else begin
      sdo_next = out_shift_reg[12]; // R06 R07
      out_shift_next = {out_shift_reg[11:0], 1'b0};
    end
  end

  always_ff @(negedge link.serial_clock or posedge frame_rst) begin
    if (frame_rst) begin
      out_shift_reg <= 13'h0000;
      sdo_reg <= 1'b0;
      oe_n_reg <= 1'b1; // R15
    end else begin
      out_shift_reg <= out_shift_next;
      sdo_reg <= sdo_next;
      oe_n_reg <= 1'b0;
    end
  end

  assign link.serial_data_out = sdo_reg;
  assign link.serial_data_out_oe_n = oe_n_reg;

  // ----------------------------------------
  // Core domain: synchronisers
  // ----------------------------------------
  logic cs_s1_reg, cs_s2_reg, cv_s1_reg, cv_s2_reg, cv_prev_reg;
  logic tg_s1_reg, tg_s2_reg, tg_seen_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cv_s1_reg <= 1'b1;
      cv_s2_reg <= 1'b1;
      cv_prev_reg <= 1'b1;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_seen_reg <= 1'b0;
    end else begin
      cs_s1_reg <= link.chip_select_n;
      cs_s2_reg <= cs_s1_reg;
      cv_s1_reg <= link.convert_start_n;
      cv_s2_reg <= cv_s1_reg;
      cv_prev_reg <= cv_s2_reg;
      tg_s1_reg <= word_tgl_reg;
      tg_s2_reg <= tg_s1_reg;
      tg_seen_reg <= tg_s2_reg;
    end
  end

  // ----------------------------------------
  // Core domain: config, conversion, pins
  // ----------------------------------------
  logic [3:0] cfg_reg, cfg_next;
  logic [11:0] lim_lo_reg, lim_lo_next, lim_hi_reg, lim_hi_next;
  logic [11:0] held_reg, held_next;
  logic [12:0] result_reg, result_next, hold_next;
  logic [7:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next, alert_reg, alert_next, pulse_next;
  logic status_reg, status_next, general_output_one_reg, general_output_one_next, out_of_limit;
  asp_pkg::asp_mode_t mode;

  always_comb begin
    cfg_next = cfg_reg;
    lim_lo_next = lim_lo_reg;
    lim_hi_next = lim_hi_reg;
    held_next = held_reg;
    result_next = result_reg;
    hold_next = hold_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    alert_next = alert_reg;
    pulse_next = 1'b0;
    out_of_limit = (held_reg < lim_lo_reg) || (held_reg > lim_hi_reg);
    // Word is stable here: the next one needs a whole frame
    if ((tg_s2_reg ^ tg_seen_reg) && word_reg[asp_pkg::WR_BIT]) begin
      unique case (word_reg[asp_pkg::ADDR_LO +: 2])
        asp_pkg::ADDR_CFG: cfg_next = word_reg[asp_pkg::CFG_BITS-1:0]; // R03
        asp_pkg::ADDR_LIM_LOW: lim_lo_next = word_reg[asp_pkg::DATA_BITS-1:0];
        asp_pkg::ADDR_LIM_HIGH: lim_hi_next = word_reg[asp_pkg::DATA_BITS-1:0];
        default: cfg_next = cfg_reg;
      endcase
    end
    // Edge, not level; a new edge during a conversion is dropped
    if (!busy_reg && cv_prev_reg && !cv_s2_reg) begin
      held_next = i_sample; // R10
      busy_next = 1'b1;
      cnt_next = 8'(CONV_CYCLES - 1);
      pulse_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == 8'h00) begin
        busy_next = 1'b0;
        alert_next = out_of_limit; // R12
        result_next = {out_of_limit, held_reg};
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
    end
    // Result moves to the port only between frames
    if (cs_s2_reg) begin
      hold_next = result_reg;
    end
    mode = asp_pkg::asp_mode_t'(cfg_next[asp_pkg::CFG_MODE_LO +: 2]);
    unique case (mode) // R11
      asp_pkg::ASP_MODE_ALERT: status_next = alert_next; // R12
      asp_pkg::ASP_MODE_BUSY: status_next = busy_next; // R13
      asp_pkg::ASP_MODE_GPO: status_next = cfg_next[asp_pkg::CFG_GPO0_BIT]; // R14
      default: status_next = 1'b0;
    endcase
    general_output_one_next = cfg_next[asp_pkg::CFG_GENERAL_OUTPUT_ONE_BIT];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= asp_pkg::CFG_RST; // R16
      lim_lo_reg <= asp_pkg::LIM_LOW_RST;
      lim_hi_reg <= asp_pkg::LIM_HIGH_RST;
      held_reg <= 12'h000;
      result_reg <= 13'h0000;
      hold_reg <= 13'h0000;
      cnt_reg <= 8'h00;
      busy_reg <= 1'b0;
      alert_reg <= 1'b0;
      o_hold_pulse <= 1'b0;
      status_reg <= 1'b0;
      general_output_one_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      lim_lo_reg <= lim_lo_next;
      lim_hi_reg <= lim_hi_next;
      held_reg <= held_next;
      result_reg <= result_next;
      hold_reg <= hold_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      alert_reg <= alert_next;
      o_hold_pulse <= pulse_next;
      status_reg <= status_next;
      general_output_one_reg <= general_output_one_next;
    end
  end

  assign link.shared_status_output = status_reg;
  assign link.general_output_one = general_output_one_reg;

endmodule

// [logic/asp_host.sv]
// Host end: makes the link clock by division and buffers results in a FIFO.
// Assumes one converter on the link and a user that drains the FIFO.
`timescale 1ns/1ps
module asp_fifo #(
  parameter int WIDTH = asp_pkg::RESULT_BITS,
  parameter int DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic push, pop;

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_in_data;
    end
  end

  assign o_in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_reg != rd_reg;
  assign o_out_data = mem_reg[rd_reg[AW-1:0]];
endmodule

module asp_host #(
  parameter int SCLK_HALF = asp_pkg::SCLK_HALF_CYCLES
) (
  asp_link_if.host link,
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_conv_req,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [15:0] i_cmd_word,
  output logic o_res_valid,
  input wire logic i_res_ready,
  output logic [12:0] o_res_data,
  output logic o_status,
  output logic o_general_output_one
);
  generate
    if (SCLK_HALF < 3 || SCLK_HALF > 255) begin : g_bad
      $error("SCLK_HALF must be 3 to 255 for the data-out synchroniser");
    end
  endgenerate

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_GAP} asp_hstate_t;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sdo_s1_reg, sdo_s2_reg, st_s1_reg, g1_s1_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sdo_s1_reg <= 1'b1;
      sdo_s2_reg <= 1'b1;
      st_s1_reg <= 1'b0;
      o_status <= 1'b0;
      g1_s1_reg <= 1'b0;
      o_general_output_one <= 1'b0;
    end else begin
      sdo_s1_reg <= link.serial_data_out_line;
      sdo_s2_reg <= sdo_s1_reg;
      st_s1_reg <= link.shared_status_output;
      o_status <= st_s1_reg;
      g1_s1_reg <= link.general_output_one;
      o_general_output_one <= g1_s1_reg;
    end
  end

  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  asp_hstate_t st_reg, st_next;
  logic [7:0] cnt_reg, cnt_next, cv_cnt_reg, cv_cnt_next;
  logic [4:0] bit_reg, bit_next;
  logic [15:0] tx_reg, tx_next;
  logic [12:0] rx_reg, rx_next;
  logic cs_n_reg, cs_n_next, sclk_reg, sclk_next, sdi_reg, sdi_next;
  logic push_reg, push_next, rdy_reg, rdy_next, cv_n_reg, cv_n_next;
  logic fifo_ready, take;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    cs_n_next = cs_n_reg;
    sclk_next = sclk_reg;
    sdi_next = sdi_reg;
    push_next = 1'b0;
    // Space is checked at take time; only this engine fills the FIFO
    take = i_cmd_valid && rdy_reg && fifo_ready;
    unique case (st_reg)
      H_IDLE: begin
        if (take) begin
          st_next = H_LEAD;
          tx_next = i_cmd_word;
          cs_n_next = 1'b0;
          bit_next = 5'h00;
          cnt_next = 8'(asp_pkg::CS_LEAD_CYCLES - 1);
        end
      end
      H_LEAD: begin
        if (cnt_reg == 8'h00) begin
          st_next = H_LOW;
          sclk_next = 1'b0;
          sdi_next = tx_reg[15]; // R04 R05
          tx_next = {tx_reg[14:0], 1'b0};
          cnt_next = 8'(SCLK_HALF - 1);
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      H_LOW: begin
        if (cnt_reg == 8'h00) begin
          st_next = H_HIGH;
          sclk_next = 1'b1;
          cnt_next = 8'(SCLK_HALF - 1);
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      H_HIGH: begin
        if (cnt_reg == 8'h00) begin
          if (bit_reg < 5'(asp_pkg::RESULT_BITS)) begin
            rx_next = {rx_reg[11:0], sdo_s2_reg};
          end
          bit_next = bit_reg + 5'h01;
          cnt_next = 8'(SCLK_HALF - 1);
          if (bit_reg == 5'(asp_pkg::FRAME_BITS - 1)) begin // R08
            st_next = H_GAP;
            cs_n_next = 1'b1; // R01
            push_next = 1'b1;
            cnt_next = 8'(asp_pkg::CS_GAP_CYCLES - 1);
          end else begin
            st_next = H_LOW;
            sclk_next = 1'b0;
            sdi_next = tx_reg[15];
            tx_next = {tx_reg[14:0], 1'b0};
          end
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      H_GAP: begin
        if (cnt_reg == 8'h00) begin
          st_next = H_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
    endcase
    rdy_next = (st_next == H_IDLE) && !push_next;
    // Convert start pulse, then a high time one cycle longer
    cv_n_next = cv_n_reg;
    cv_cnt_next = cv_cnt_reg;
    if (cv_cnt_reg != 8'h00) begin
      cv_cnt_next = cv_cnt_reg - 8'h01;
      if (cv_cnt_reg == 8'(asp_pkg::CONVERT_START_N_LOW_CYCLES + 1)) begin
        cv_n_next = 1'b1;
      end
    end else if (i_conv_req) begin
      cv_n_next = 1'b0; // R10
      cv_cnt_next = 8'(2 * asp_pkg::CONVERT_START_N_LOW_CYCLES);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= H_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 5'h00;
      tx_reg <= 16'h0000;
      rx_reg <= 13'h0000;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b1;
      sdi_reg <= 1'b0;
      push_reg <= 1'b0;
      rdy_reg <= 1'b0;
      cv_n_reg <= 1'b1;
      cv_cnt_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      cs_n_reg <= cs_n_next;
      sclk_reg <= sclk_next;
      sdi_reg <= sdi_next;
      push_reg <= push_next;
      rdy_reg <= rdy_next;
      cv_n_reg <= cv_n_next;
      cv_cnt_reg <= cv_cnt_next;
    end
  end

  assign link.chip_select_n = cs_n_reg;
  assign link.serial_clock = sclk_reg;
  assign link.serial_data_in = sdi_reg;
  assign link.convert_start_n = cv_n_reg;
  // rdy_reg is a flop and fifo_ready decodes flops; a full FIFO holds requests off
  assign o_cmd_ready = rdy_reg && fifo_ready;

  asp_fifo #(
    .WIDTH(asp_pkg::RESULT_BITS),
    .DEPTH(asp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(push_reg),
    .o_in_ready(fifo_ready),
    .i_in_data(rx_reg),
    .o_out_valid(o_res_valid),
    .i_out_ready(i_res_ready),
    .o_out_data(o_res_data)
  );

endmodule

// [verification/asp_link_properties.sv]
// Concurrent checks on the link between host end and converter end.
// Assumes every link signal is a flop of the core clock domain or follows one.
`timescale 1ns/1ps
module asp_link_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  input wire logic convert_start_n
);
  // ----------------------------------------
  // Falling link clock edges in a frame
  // ----------------------------------------
  logic sclk_d_reg;
  logic sclk_d_next;
  logic [4:0] fall_reg;
  logic [4:0] fall_next;

  always_comb begin
    sclk_d_next = serial_clock;
    fall_next = fall_reg;
    if (chip_select_n) begin
      fall_next = 5'h00;
    end else if (sclk_d_reg && !serial_clock) begin
      fall_next = fall_reg + 5'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d_reg <= 1'b1;
      fall_reg <= 5'h00;
    end else begin
      sclk_d_reg <= sclk_d_next;
      fall_reg <= fall_next;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  idle_clock_a: assert property (chip_select_n |-> serial_clock)
    else $error("link clock moved outside a frame");
  frame_lead_a: assert property ($fell(chip_select_n) |-> serial_clock [*6] ##1 !serial_clock)
    else $error("frame lead time wrong");
  frame_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n [*4])
    else $error("frame gap too short");
  sdi_setup_a: assert property ($rose(serial_clock) |-> $stable(serial_data_in))
    else $error("data in moved at rising edge");
  sdo_drive_a: assert property (!chip_select_n && !serial_clock |-> !serial_data_out_oe_n)
    else $error("data out not driven in frame");
  sdo_edge_a: assert property (!chip_select_n && !$past(chip_select_n)
    && $changed(serial_data_out) |-> $fell(serial_clock))
    else $error("data out moved off falling edge");
  clock_count_a: assert property ($rose(chip_select_n) |-> fall_reg == 5'h10)
    else $error("wrong clock count in frame");
  convert_start_n_pulse_a: assert property ($fell(convert_start_n)
    |-> ##1 !convert_start_n ##1 convert_start_n [*2])
    else $error("convert start pulse shape wrong");
  sdo_release_a: assert property (chip_select_n |-> serial_data_out_oe_n)
    else $error("data out driven while deselected");
endmodule

// [verification/tb_adc_serial_port_and_convert_control.sv]
// Bench joining host end and converter end through the link interface.
// Assumes the host end makes the link clock itself from i_clk.
`timescale 1ns/1ps
module tb_adc_serial_port_and_convert_control;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_conv_req = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic i_res_ready = 1'b0;
  logic [15:0] i_cmd_word = 16'h0000;
  logic [11:0] i_sample = 12'h000;
  logic o_cmd_ready, o_res_valid, o_status, o_general_output_one, o_hold_pulse, mid;
  logic [12:0] o_res_data;
  logic [15:0] sdi_bits = 16'h0000;
  logic [15:0] sdo_bits = 16'h0000;
  logic [12:0] tbl [5] = '{13'h1900, 13'h1050, 13'h0400, 13'h0100, 13'h0800};
  logic [5:0] mtb [4] = '{6'h3B, 6'h1A, 6'h08, 6'h3D};
  int failures = 0;
  int tests_run = 0;

  asp_link_if link ();
  asp_dev asp_dev_i (.link(link), .i_clk(i_clk), .i_rst(i_rst), .i_sample(i_sample),
    .o_hold_pulse(o_hold_pulse));
  asp_host asp_host_i (.link(link), .i_clk(i_clk), .i_rst(i_rst), .i_conv_req(i_conv_req),
    .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready), .i_cmd_word(i_cmd_word),
    .o_res_valid(o_res_valid), .i_res_ready(i_res_ready), .o_res_data(o_res_data),
    .o_status(o_status), .o_general_output_one(o_general_output_one));
  asp_link_properties asp_link_properties_i (.i_clk(i_clk), .i_rst(i_rst),
    .serial_clock(link.serial_clock), .chip_select_n(link.chip_select_n),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out),
    .serial_data_out_oe_n(link.serial_data_out_oe_n),
    .convert_start_n(link.convert_start_n));

  initial forever #10 i_clk = ~i_clk;

  // Wire capture at each rising link clock edge inside a frame
  always @(posedge link.serial_clock) begin
    if (link.chip_select_n === 1'b0) begin
      sdi_bits <= {sdi_bits[14:0], link.serial_data_in};
      sdo_bits <= {sdo_bits[14:0], link.serial_data_out_line};
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task wait_cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Ready is stable between edges, so seeing it at the falling edge means taken at the next
  task send(input logic [15:0] w);
    int k;
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd_word = w;
    for (k = 0; k < 500 && o_cmd_ready !== 1'b1; k++) @(negedge i_clk);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
  endtask

  task pop(input logic [12:0] exp);
    int k;
    // Lets an edge pass so back-to-back pops never drive ready twice at once
    @(negedge i_clk);
    for (k = 0; k < 500 && o_res_valid !== 1'b1; k++) @(negedge i_clk);
    check(o_res_data, exp);
    i_res_ready = 1'b1;
    @(negedge i_clk);
    i_res_ready = 1'b0;
  endtask

  task frame(input logic [15:0] w, input logic [12:0] exp);
    send(w);
    pop(exp);
    check(sdi_bits, w);
    check(sdo_bits[15:3], exp);
  endtask

  task convert(input logic [11:0] s, output logic busy);
    int k;
    @(negedge i_clk);
    i_sample = s;
    i_conv_req = 1'b1;
    @(negedge i_clk);
    i_conv_req = 1'b0;
    for (k = 0; k < 20 && o_hold_pulse !== 1'b1; k++) @(negedge i_clk);
    check(o_hold_pulse, 1'b1);
    wait_cyc(8);
    busy = o_status;
    wait_cyc(40);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    check({link.chip_select_n, link.serial_clock, link.serial_data_out_oe_n, o_status, o_general_output_one},
      16'h001C);
    convert(12'hA5C, mid);
    frame(16'h0000, 13'h0A5C);
    frame(16'hA100, 13'h0A5C);
    frame(16'hC800, 13'h0A5C);
    for (int i = 0; i < 5; i++) begin
      convert(tbl[i][11:0], mid);
      frame(16'h0000, tbl[i]);
      wait_cyc(6);
      check(o_status, tbl[i][12]);
    end
    for (int i = 0; i < 4; i++) begin
      frame({12'h800, mtb[i][5:2]}, 13'h0800);
      wait_cyc(8);
      check({o_status, o_general_output_one}, mtb[i][1:0]);
    end
    frame(16'h8001, 13'h0800);
    convert(12'h123, mid);
    check(mid, 1'b1);
    check(o_status, 1'b0);
    frame(16'h0000, 13'h0123);
    repeat (16) send(16'h0000);
    wait_cyc(300);
    check(o_cmd_ready, 1'b0);
    repeat (16) pop(13'h0123);
    check(o_res_valid, 1'b0);
    frame(16'h800E, 13'h0123);
    wait_cyc(8);
    check(o_general_output_one, 1'b1);
    i_rst = 1'b1;
    wait_cyc(3);
    i_rst = 1'b0;
    wait_cyc(8);
    check({o_status, o_general_output_one}, 16'h0000);
    convert(12'hF00, mid);
    frame(16'h0000, 13'h0F00);
    stop_test;
  end

  initial begin
    #(20 * 30000);
    failures++;
    stop_test;
  end
endmodule
